// *** bench/bcu_branch_unit_sva.sv ***
`timescale 1ns/100ps
module bcu_branch_checker (
    input wire logic                          clock_i,                 // clock
    input wire logic                          resetn_i,                // sync reset, low
    input wire logic                          req_valid_i,             // request
    input wire logic [bcu_pkg::INSTR_W-1:0]   instr_i,                 // instruction
    input wire logic [bcu_pkg::WORD_W-1:0]    operand_register_i,      // operand
    input wire logic [bcu_pkg::ADDR_W-1:0]    first_index_register_i,  // first index
    input wire logic [bcu_pkg::ADDR_W-1:0]    second_index_register_i, // second index
    input wire logic                          resp_valid_o,            // decision pulse
    input wire logic                          taken_o,                 // taken
    input wire logic [bcu_pkg::ADDR_W-1:0]    target_o,                // target
    input wire logic                          flush_word_o             // drop rest of word
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    logic [5:0]  opc;
    logic [2:0]  ts;
    logic [11:0] ex;
    logic [18:0] raw;
    logic [17:0] sum;
    logic        t3, zero, ovf, indef, eq, ge;
    assign opc   = instr_i[29:24];
    assign ts    = instr_i[23:21];
    assign ex    = operand_register_i[59:48];
    assign t3    = req_valid_i && opc == bcu_pkg::OPC_OPERAND_TEST;
    assign zero  = operand_register_i == '0 || operand_register_i == '1;
    assign ovf   = ex == bcu_pkg::EXP_POS_OVERFLOW || ex == bcu_pkg::EXP_NEG_OVERFLOW;
    assign indef = ex == bcu_pkg::EXP_POS_INDEFINITE || ex == bcu_pkg::EXP_NEG_INDEFINITE;
    assign raw   = {1'b0, first_index_register_i} + {1'b0, instr_i[17:0]};
    assign sum   = raw[17:0] + 18'(raw[18]);
    assign eq    = first_index_register_i == second_index_register_i;
    // one's complement order: sign decides first, +0 above -0
    assign ge    = first_index_register_i[17] != second_index_register_i[17] ?
                   !first_index_register_i[17] : first_index_register_i >= second_index_register_i;
    chk_target_k: assert property (
        req_valid_i && opc inside {[6'h03:6'h06]} |=> resp_valid_o && target_o == $past(instr_i[17:0]))
        else $error("target is not K");
    chk_computed_sum: assert property (
        req_valid_i && opc == 6'h02 |=> taken_o && flush_word_o && target_o == $past(sum))
        else $error("computed jump wrong");
    chk_zero_test: assert property (
        t3 && ts == 3'h0 |=> taken_o == $past(zero))
        else $error("zero test wrong");
    chk_nonzero_test: assert property (t3 && ts == 3'h1 |=> taken_o == !$past(zero))
        else $error("nonzero test wrong");
    chk_sign_pos: assert property (t3 && ts == 3'h2 |=> taken_o != $past(ex[11]))
        else $error("positive test wrong");
    chk_out_range: assert property (t3 && ts == 3'h5 |=> taken_o == $past(ovf))
        else $error("out of range test wrong");
    chk_indef_test: assert property (t3 && ts == 3'h7 |=> taken_o == $past(indef))
        else $error("indefinite test wrong");
    chk_index_ne: assert property (
        req_valid_i && opc == 6'h05 |=> taken_o == !$past(eq))
        else $error("index unequal wrong");
    chk_index_ge: assert property (
        req_valid_i && opc == 6'h06 |=> taken_o == $past(ge))
        else $error("index ge wrong");
endmodule : bcu_branch_checker

bind bcu_branch_unit bcu_branch_checker u_bcu_branch_checker (.clock_i, .resetn_i,
    .req_valid_i, .instr_i, .operand_register_i, .first_index_register_i,
    .second_index_register_i, .resp_valid_o, .taken_o, .target_o, .flush_word_o);

// *** bench/bcu_branch_unit_test.sv ***
`timescale 1ns/100ps
module bcu_branch_unit_test;
    logic        clock_i = 1'b0, resetn_i = 1'b0, req_valid_i = 1'b0;
    logic        resp_valid_o, taken_o, flush_word_o, unsupported_o;
    logic [29:0] instr_i = '0;
    logic [59:0] operand_register_i = '0;
    logic [17:0] first_index_register_i = '0, second_index_register_i = '0, target_o, fetch_addr;
    logic [2:0]  first_sel_o, second_sel_o;
    int          fail_count = 0, tests_run = 0;
    bcu_branch_unit u_bcu_branch_unit (.clock_i, .resetn_i, .req_valid_i, .instr_i,
        .operand_register_i, .first_index_register_i, .second_index_register_i, .resp_valid_o,
        .taken_o, .target_o, .flush_word_o, .unsupported_o, .first_sel_o, .second_sel_o);
    bcu_fetch_model u_bcu_fetch_model (.clock_i, .resetn_i, .resp_valid_i(resp_valid_o),
        .taken_i(taken_o), .flush_word_i(flush_word_o), .target_i(target_o),
        .fetch_addr_o(fetch_addr));
    initial begin
        forever #4 clock_i = ~clock_i;
    end
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    // one request, answer checked right after the edge that registers it
    task automatic run_op(input logic [29:0] ins, input logic [59:0] x,
                          input logic [17:0] a, input logic [17:0] b, input logic tk);
        @(posedge clock_i);
        req_valid_i <= 1'b1;
        instr_i <= ins;
        operand_register_i <= x;
        first_index_register_i <= a;
        second_index_register_i <= b;
        @(posedge clock_i);
        req_valid_i <= 1'b0;
        #1;
        check(resp_valid_o, 1'b1);
        check(taken_o, tk);
        check(flush_word_o, tk);
    endtask : run_op
    task automatic test_computed_jump();
        logic [17:0] a[3] = '{18'h3FFFE, 18'h3FFFF, 18'h00010};
        logic [17:0] k[3] = '{18'h00005, 18'h00000, 18'h3FFFF};
        logic [18:0] s;
        foreach (a[n]) begin
            s = {1'b0, a[n]} + {1'b0, k[n]};
            run_op({6'h02, 3'h1, 3'h2, k[n]}, '0, a[n], 18'h00000, 1'b1);
            check(target_o, s[17:0] + s[18]);
            @(posedge clock_i);
            #1;
            check(fetch_addr, s[17:0] + s[18]);
        end
        $display("computed jump done");
    endtask : test_computed_jump
    task automatic test_operand_tests();
        logic [59:0] x[7] = '{60'h0, '1, {12'h7FF, 48'h1}, {12'h800, 48'h0}, {12'h3FF, 48'h5},
                              {12'hC00, 48'h0}, {12'h001, 48'h8}};
        logic [7:0]  e;
        logic        z, o, d;
        logic [29:0] ins;
        for (int s = 0; s < 8; s++) begin
            ins = {6'h03, s[2:0], 3'h4, 15'h5A5, s[2:0]};
            foreach (x[n]) begin
                z = x[n] == '0 || x[n] == '1;
                o = x[n][59:48] == 12'h7FF || x[n][59:48] == 12'h800;
                d = x[n][59:48] == 12'h3FF || x[n][59:48] == 12'hC00;
                e = {d, !d, o, !o, x[n][59], !x[n][59], !z, z};
                run_op(ins, x[n], '0, '0, e[s]);
                check(target_o, {15'h5A5, s[2:0]});
            end
        end
        $display("operand tests done");
    endtask : test_operand_tests
    task automatic test_index_compare();
        logic [17:0] a[6] = '{18'h0, 18'h0, 18'h3FFFF, 18'h5, 18'h3FFFE, 18'h1};
        logic [17:0] b[6] = '{18'h0, 18'h3FFFF, 18'h0, 18'h6, 18'h1, 18'h3FFFE};
        logic        q, g;
        foreach (a[n]) begin
            q = a[n] === b[n];
            g = a[n][17] != b[n][17] ? !a[n][17] : a[n] >= b[n];
            run_op({6'h04, 3'h5, 3'h2, 18'h00ABC}, '0, a[n], b[n], q);
            check({first_sel_o, second_sel_o}, 6'h2A);
            run_op({6'h05, 3'h5, 3'h2, 18'h00ABC}, '0, a[n], b[n], !q);
            run_op({6'h06, 3'h5, 3'h2, 18'h00ABC}, '0, a[n], b[n], g);
            check(target_o, 18'h00ABC);
        end
        $display("index compare done");
    endtask : test_index_compare
    task automatic test_unsupported_b2b();
        run_op({6'h07, 6'h00, 18'h00042}, '0, '0, '0, 1'b0);
        check(unsupported_o, 1'b1);
        @(posedge clock_i);
        req_valid_i <= 1'b1;
        instr_i <= {6'h03, 3'h0, 3'h0, 18'h00011};
        operand_register_i <= '0;
        @(posedge clock_i);
        instr_i <= {6'h03, 3'h2, 3'h0, 18'h00022};
        operand_register_i <= '1;
        #1;
        check(taken_o, 1'b1);
        check(unsupported_o, 1'b0);
        check(target_o, 18'h00011);
        @(posedge clock_i);
        req_valid_i <= 1'b0;
        #1;
        check(taken_o, 1'b0);
        check(target_o, 18'h00022);
        $display("unsupported and back to back done");
    endtask : test_unsupported_b2b
    initial begin
        repeat (4) @(posedge clock_i);
        resetn_i <= 1'b1;
        test_computed_jump();
        test_operand_tests();
        test_index_compare();
        test_unsupported_b2b();
        stop_test();
    end
    initial begin
        repeat (5000) @(posedge clock_i);
        fail_count++;
        stop_test();
    end
endmodule : bcu_branch_unit_test

// *** bench/bcu_fetch_model.sv ***
`timescale 1ns/100ps
module bcu_fetch_model (
    input  wire logic        clock_i,      // clock
    input  wire logic        resetn_i,     // sync reset, low
    input  wire logic        resp_valid_i, // decision pulse
    input  wire logic        taken_i,      // branch taken
    input  wire logic        flush_word_i, // drop rest of word
    input  wire logic [17:0] target_i,     // branch target
    output logic      [17:0] fetch_addr_o  // next fetch address
);
    logic [17:0] next_fetch_addr;
    always_comb begin
        next_fetch_addr = fetch_addr_o;
        if (resp_valid_i && taken_i && flush_word_i) next_fetch_addr = target_i;
        else if (resp_valid_i) next_fetch_addr = fetch_addr_o + 18'h00001;
    end
    always_ff @(posedge clock_i) begin
        fetch_addr_o <= resetn_i ? next_fetch_addr : 18'h00000;
    end
endmodule : bcu_fetch_model

// *** rtl/bcu_branch_unit.sv ***
`timescale 1ns/100ps
// branch decision for jump instructions; one request per cycle, answer one cycle later
module bcu_branch_unit (
    input  wire logic                       clock_i,                 // 125 MHz clock
    input  wire logic                       resetn_i,                // sync reset, low
    input  wire logic                       req_valid_i,             // instruction present
    input  wire logic [bcu_pkg::INSTR_W-1:0] instr_i,                // two-parcel instruction
    input  wire logic [bcu_pkg::WORD_W-1:0] operand_register_i,      // operand contents
    input  wire logic [bcu_pkg::ADDR_W-1:0] first_index_register_i,  // first index contents
    input  wire logic [bcu_pkg::ADDR_W-1:0] second_index_register_i, // second index contents
    output logic                            resp_valid_o,            // decision pulse
    output logic                            taken_o,                 // branch taken
    output logic [bcu_pkg::ADDR_W-1:0]      target_o,                // memory target
    output logic                            flush_word_o,            // drop rest of word
    output logic                            unsupported_o,           // opcode not handled
    output logic [bcu_pkg::SEL_W-1:0]       first_sel_o,             // decoded first index
    output logic [bcu_pkg::SEL_W-1:0]       second_sel_o             // decoded second index
);
    typedef enum logic [2:0] {
        BCU_CLS_NONE     = 3'h0,
        BCU_CLS_COMPUTED = 3'h1,
        BCU_CLS_OPERAND  = 3'h3,
        BCU_CLS_EQUAL    = 3'h2,
        BCU_CLS_UNEQUAL  = 3'h6,
        BCU_CLS_GE       = 3'h7
    } bcu_class_e;

    logic [5:0]                  opcode;
    logic [bcu_pkg::SEL_W-1:0]   first_sel;
    logic [bcu_pkg::SEL_W-1:0]   second_sel;
    logic [bcu_pkg::ADDR_W-1:0]  k_field;
    logic [bcu_pkg::EXP_W-1:0]   exponent;
    bcu_class_e                  branch_class;

    logic                        is_zero;
    logic                        is_overflow;
    logic                        is_indefinite;
    logic                        sign_set;
    logic                        operand_jump;
    logic                        index_equal;
    logic                        index_ge;
    logic [bcu_pkg::ADDR_W-1:0]  computed_target;

    logic                        resp_valid;
    logic                        taken;
    logic [bcu_pkg::ADDR_W-1:0]  target;
    logic                        flush_word;
    logic                        unsupported;
    logic [bcu_pkg::SEL_W-1:0]   first_sel_q;
    logic [bcu_pkg::SEL_W-1:0]   second_sel_q;

    logic                        next_resp_valid;
    logic                        next_taken;
    logic [bcu_pkg::ADDR_W-1:0]  next_target;
    logic                        next_flush_word;
    logic                        next_unsupported;
    logic [bcu_pkg::SEL_W-1:0]   next_first_sel;
    logic [bcu_pkg::SEL_W-1:0]   next_second_sel;

    // field extraction
    always_comb begin
        opcode     = instr_i[bcu_pkg::OPC_HI:bcu_pkg::OPC_LO];
        first_sel  = instr_i[bcu_pkg::FIRST_HI:bcu_pkg::FIRST_LO];
        second_sel = instr_i[bcu_pkg::SECOND_HI:bcu_pkg::SECOND_LO];
        k_field    = instr_i[bcu_pkg::K_HI:bcu_pkg::K_LO];
        exponent   = operand_register_i[bcu_pkg::SIGN_BIT:bcu_pkg::EXP_LO];
    end

    // opcode class decode
    always_comb begin
        case (opcode)
            bcu_pkg::OPC_COMPUTED_JUMP: begin
                branch_class = BCU_CLS_COMPUTED;
            end
            bcu_pkg::OPC_OPERAND_TEST: begin
                branch_class = BCU_CLS_OPERAND;
            end
            bcu_pkg::OPC_INDEX_EQUAL: begin
                branch_class = BCU_CLS_EQUAL;
            end
            bcu_pkg::OPC_INDEX_UNEQUAL: begin
                branch_class = BCU_CLS_UNEQUAL;
            end
            bcu_pkg::OPC_INDEX_GE: begin
                branch_class = BCU_CLS_GE;
            end
            default: begin
                branch_class = BCU_CLS_NONE;
            end
        endcase
    end

    // first index plus K, end-around carry
    bcu_ones_add #(
        .WIDTH (bcu_pkg::ADDR_W)
    ) u_computed_add (
        .a_i   (first_index_register_i),
        .b_i   (k_field),
        .sum_o (computed_target)
    );

    // operand classification
    always_comb begin
        is_zero = (operand_register_i == {bcu_pkg::WORD_W{1'b0}})
               || (operand_register_i == {bcu_pkg::WORD_W{1'b1}});
        sign_set      = operand_register_i[bcu_pkg::SIGN_BIT];
        is_overflow   = (exponent == bcu_pkg::EXP_POS_OVERFLOW)
                     || (exponent == bcu_pkg::EXP_NEG_OVERFLOW);
        // coefficient never looked at; underflow falls through as in range
        is_indefinite = (exponent == bcu_pkg::EXP_POS_INDEFINITE)
                     || (exponent == bcu_pkg::EXP_NEG_INDEFINITE);
    end

    // operand test select
    always_comb begin
        case (first_sel)
            bcu_pkg::TST_ZERO: begin
                operand_jump = is_zero;
            end
            bcu_pkg::TST_NONZERO: begin
                operand_jump = !is_zero;
            end
            bcu_pkg::TST_POSITIVE: begin
                operand_jump = !sign_set;
            end
            bcu_pkg::TST_NEGATIVE: begin
                operand_jump = sign_set;
            end
            bcu_pkg::TST_IN_RANGE: begin
                operand_jump = !is_overflow;
            end
            bcu_pkg::TST_OUT_RANGE: begin
                operand_jump = is_overflow;
            end
            bcu_pkg::TST_DEFINITE: begin
                operand_jump = !is_indefinite;
            end
            bcu_pkg::TST_INDEFINITE: begin
                operand_jump = is_indefinite;
            end
            default: begin
                operand_jump = 1'b0;
            end
        endcase
    end

    // index comparisons
    always_comb begin
        // raw bit compare keeps +0 and -0 apart
        index_equal = (first_index_register_i == second_index_register_i);
        // signs differ: positive side wins, so +0 ranks above -0
        if (first_index_register_i[bcu_pkg::ADDR_W-1]
                != second_index_register_i[bcu_pkg::ADDR_W-1]) begin
            index_ge = !first_index_register_i[bcu_pkg::ADDR_W-1];
        end else begin
            // same sign: one's complement order matches unsigned order
            index_ge = (first_index_register_i >= second_index_register_i);
        end
    end

    // decision and target
    always_comb begin
        next_resp_valid  = req_valid_i;
        next_taken       = 1'b0;
        next_target      = k_field;
        next_flush_word  = 1'b0;
        next_unsupported = 1'b0;
        next_first_sel   = first_sel_q;
        next_second_sel  = second_sel_q;
        if (req_valid_i) begin
            next_first_sel  = first_sel;
            next_second_sel = second_sel;
            case (branch_class)
                BCU_CLS_COMPUTED: begin
                    next_taken      = 1'b1;
                    next_target     = computed_target;
                    next_flush_word = 1'b1;
                end
                BCU_CLS_OPERAND: begin
                    next_taken = operand_jump;
                end
                BCU_CLS_EQUAL: begin
                    next_taken = index_equal;
                end
                BCU_CLS_UNEQUAL: begin
                    next_taken = !index_equal;
                end
                BCU_CLS_GE: begin
                    next_taken = index_ge;
                end
                default: begin
                    next_unsupported = 1'b1;
                end
            endcase
            // any taken jump ends the current sequence
            if (next_taken) begin
                next_flush_word = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            resp_valid   <= 1'b0;
            taken        <= 1'b0;
            target       <= bcu_pkg::TARGET_RESET;
            flush_word   <= 1'b0;
            unsupported  <= 1'b0;
            first_sel_q  <= 3'h0;
            second_sel_q <= 3'h0;
        end else begin
            resp_valid   <= next_resp_valid;
            taken        <= next_taken;
            target       <= next_target;
            flush_word   <= next_flush_word;
            unsupported  <= next_unsupported;
            first_sel_q  <= next_first_sel;
            second_sel_q <= next_second_sel;
        end
    end

    always_comb begin
        resp_valid_o  = resp_valid;
        taken_o       = taken;
        target_o      = target;
        flush_word_o  = flush_word;
        unsupported_o = unsupported;
        first_sel_o   = first_sel_q;
        second_sel_o  = second_sel_q;
    end
endmodule : bcu_branch_unit

// *** rtl/bcu_ones_add.sv ***
`timescale 1ns/100ps
// one's complement adder with end-around carry
module bcu_ones_add #(
    parameter int WIDTH = 18
) (
    input  wire logic [WIDTH-1:0] a_i,    // addend
    input  wire logic [WIDTH-1:0] b_i,    // addend
    output logic      [WIDTH-1:0] sum_o   // one's complement sum
);
    logic [WIDTH:0] raw;

    always_comb begin
        raw   = {1'b0, a_i} + {1'b0, b_i};
        sum_o = raw[WIDTH-1:0] + {{(WIDTH-1){1'b0}}, raw[WIDTH]};
    end
endmodule : bcu_ones_add

// *** rtl/bcu_pkg.sv ***
// What this block does
// - conditional two-parcel branches (opcodes 03 to 06) take K from the low 18 instruction bits as target
// - computed jump adds index and K in 18-bit one's complement, unsigned result
// - computed jump drops rest of instruction word, fetch resumes at computed target
// - zero test jumps when operand is all zeros or all ones (positive or negative zero)
// - nonzero test jumps exactly when zero test would continue
// - positive test jumps when operand sign bit 59 is clear
// - negative test jumps when operand sign bit 59 is set
// - in-range test continues on overflow exponents 3777 or 4000, else jumps
// - out-of-range test jumps only on overflow exponents 3777 or 4000
// - definite test continues on indefinite exponents 1777 or 6000, else jumps
// - indefinite test jumps only on indefinite exponent; overflow, underflow are defined
// - index-equal test jumps only on bitwise match; all zeros differs from all ones
// - index-unequal test jumps on any differing bit, continues only when identical
// - greater-or-equal compares signed; positive zero ranks above negative zero
// - opcode bits 29-24, first index 23-21, second 20-18, K 17-0
package bcu_pkg;
    localparam int ADDR_W  = 18;
    localparam int WORD_W  = 60;
    localparam int INSTR_W = 30;
    localparam int SEL_W   = 3;
    localparam int EXP_W   = 12;

    // instruction and operand field positions
    localparam int OPC_HI   = 29;
    localparam int OPC_LO   = 24;
    localparam int FIRST_HI = 23;
    localparam int FIRST_LO = 21;
    localparam int SECOND_HI = 20;
    localparam int SECOND_LO = 18;
    localparam int K_HI     = 17;
    localparam int K_LO     = 0;
    localparam int SIGN_BIT = 59;
    localparam int EXP_LO   = 48;

    // major opcodes, bits 29-24
    localparam logic [5:0] OPC_COMPUTED_JUMP = 6'h02;
    localparam logic [5:0] OPC_OPERAND_TEST  = 6'h03;
    localparam logic [5:0] OPC_INDEX_EQUAL   = 6'h04;
    localparam logic [5:0] OPC_INDEX_UNEQUAL = 6'h05;
    localparam logic [5:0] OPC_INDEX_GE      = 6'h06;

    // operand tests, bits 23-21 under opcode 03
    localparam logic [2:0] TST_ZERO       = 3'h0;
    localparam logic [2:0] TST_NONZERO    = 3'h1;
    localparam logic [2:0] TST_POSITIVE   = 3'h2;
    localparam logic [2:0] TST_NEGATIVE   = 3'h3;
    localparam logic [2:0] TST_IN_RANGE   = 3'h4;
    localparam logic [2:0] TST_OUT_RANGE  = 3'h5;
    localparam logic [2:0] TST_DEFINITE   = 3'h6;
    localparam logic [2:0] TST_INDEFINITE = 3'h7;

    // exponent patterns (octal 3777, 4000, 1777, 6000)
    localparam logic [EXP_W-1:0] EXP_POS_OVERFLOW   = 12'h7FF;
    localparam logic [EXP_W-1:0] EXP_NEG_OVERFLOW   = 12'h800;
    localparam logic [EXP_W-1:0] EXP_POS_INDEFINITE = 12'h3FF;
    localparam logic [EXP_W-1:0] EXP_NEG_INDEFINITE = 12'hC00;

    localparam logic [ADDR_W-1:0] TARGET_RESET = 18'h00000;
endpackage : bcu_pkg
